// File: rtl/cttc_pkg.sv
// Purpose: constants, field layout and types of the charge configuration bank
// Assumes: 200 MHz MCLK, 8-bit registers behind a two-wire serial port
// Notes: decode figures in mA, mV, seconds, minutes and hours
`default_nettype none
package cttc_pkg;
	// register offsets and power-on values
	localparam logic [7:0] PRECHG_TERM_ADDR = 8'h03;
	localparam logic [7:0] CHARGE_VOLTAGE_CODE_TOPOFF_ADDR = 8'h04;
	localparam logic [7:0] TERM_WD_TIMER_ADDR = 8'h05;
	localparam logic [7:0] PRECHG_TERM_POR = 8'h22;
	localparam logic [7:0] CHARGE_VOLTAGE_CODE_TOPOFF_POR = 8'h58;
	localparam logic [7:0] TERM_WD_TIMER_POR = 8'h9f;
	// field positions
	localparam int PRECHG_LSB = 4;
	localparam int TERM_LSB = 0;
	localparam int CHARGE_VOLTAGE_CODE_LSB = 3;
	localparam int TOPOFF_LSB = 1;
	localparam int RECHG_BIT = 0;
	localparam int TERM_EN_BIT = 7;
	localparam int WD_LSB = 4;
	localparam int TIMER_EN_BIT = 3;
	localparam int SAFETY_LEN_BIT = 2;
	localparam int TLIM_BIT = 1;
	localparam int COLD_BIT = 0;
	// decode figures
	localparam int CUR_OFS_MA = 60;
	localparam int CUR_STEP_MA = 60;
	localparam int PRECHG_MAX_CODE = 12;
	localparam int CHARGE_VOLTAGE_CODE_OFS_MV = 3856;
	localparam int CHARGE_VOLTAGE_CODE_STEP_MV = 32;
	localparam int CHARGE_VOLTAGE_CODE_MAX_CODE = 24;
	localparam int CHARGE_VOLTAGE_CODE_SPECIAL_CODE = 15;
	localparam int CHARGE_VOLTAGE_CODE_SPECIAL_MV = 4352;
	localparam int RECHG_LOW_MV = 100;
	localparam int RECHG_HIGH_MV = 200;
	localparam int TLIM_LOW_C = 80;
	localparam int TLIM_HIGH_C = 120;
	localparam int COLD_HALF_PCT = 50;
	localparam int COLD_FIFTH_PCT = 20;
	// timing
	localparam longint CLK_HZ = 200_000_000;
	localparam longint TICK_S = 1;
	localparam int SEC_CYCLES_DEF = int'(CLK_HZ * TICK_S);
	localparam int TOPOFF_STEP_MIN = 15;
	localparam int WD_BASE_S = 40;
	localparam int SAFETY_SHORT_HR = 4;
	localparam int SAFETY_LONG_HR = 6;
	localparam int SEC_PER_MIN = 60;
	localparam int SEC_PER_HR = 3600;
	localparam int TIMER_W = 15;

	typedef struct packed {
		logic [9:0] precharge_ma;
		logic [9:0] term_ma;
		logic [12:0] charge_voltage_code_mv;
		logic [5:0] topoff_min;
		logic [7:0] recharge_ofs_mv;
		logic term_en;
		logic [7:0] watchdog_s;
		logic timer_en;
		logic [2:0] safety_hrs;
		logic [6:0] thermal_c;
		logic [6:0] cold_pct;
	} cttc_cfg_s;

	// serial port states, gray along the usual path
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_AACK = 4'h3,
		ST_PTR = 4'h2,
		ST_PACK = 4'h6,
		ST_WR = 4'h7,
		ST_WACK = 4'h5,
		ST_RD = 4'h4,
		ST_RACK = 4'hc
	} cttc_st_e;
endpackage
`default_nettype wire

// File: rtl/cttc_regs.sv
// Purpose: charge current, voltage and timer configuration bank on a serial port
// Assumes: charger status inputs come from logic on MCLK
// Notes: device address is a parameter; unmapped offsets read zero
// Function
// - pre-charge code decodes as 60 mA plus 60 mA per step
// - pre-charge codes above twelve act as twelve, 780 mA
// - termination code decodes as 60 mA plus 60 mA per step
// - voltage code decodes as 3856 mV plus 32 mV per step
// - voltage code fifteen gives fixed 4352 mV
// - voltage codes above twenty-four act as twenty-four
// - top-off extension: off, 15, 30 or 45 minutes
// - with top-off off, charge ends at termination at once
// - recharge when full battery drops below limit minus 100 or 200 mV
// - watchdog: off, 40, 80 or 160 seconds
// - safety timer counts pre-charge and fast charge when enabled
// - safety timer length four or six hours, six by default
// - thermal regulation threshold 80 or 120 degrees
// - cold zone current half or one fifth of programmed
// - current register loads 8'h22 at power-on
// - voltage register loads 8'h58 at power-on
// - control register loads 8'h9f at power-on
`timescale 1ns/1ps
`default_nettype none
module cttc_regs
	import cttc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h55, // arbitrary value
	parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
	// clock and reset
	input wire logic MCLK,
	input wire logic RESET_N,
	// serial port
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	// register reset and watchdog
	input wire logic REG_RESET,
	input wire logic WATCHDOG_RESTART,
	output logic WATCHDOG_RESTART_CLEAR,
	output logic WATCHDOG_EXPIRED,
	// charger status
	input wire logic PRECHARGE_ACTIVE,
	input wire logic FASTCHARGE_ACTIVE,
	input wire logic TERM_DETECT,
	input wire logic [12:0] VBAT_MV,
	// charger control
	output logic CHARGE_DONE,
	output logic RECHARGE_START,
	output logic SAFETY_EXPIRED,
	output cttc_cfg_s CFG
);
	typedef struct packed {
		logic [7:0] r03;
		logic [7:0] r04;
		logic [7:0] r05;
		cttc_cfg_s cfg;
		cttc_st_e st;
		logic [3:0] bitcnt;
		logic [7:0] sr;
		logic [7:0] tx;
		logic [7:0] ptr;
		logic rw;
		logic ack_ok;
		logic sda_oe;
		logic scl_p;
		logic sda_p;
		logic done;
		logic rchg;
		logic wd_clr;
	} cttc_core_s;
	cttc_core_s q, d;

	logic scl, sda;
	logic wd_exp, safe_exp, top_exp;
	logic wd_run, wd_clear, safe_run, safe_clear, top_run, top_clear;
	logic term_cond, por_load;
	logic [1:0] wd_code, top_code;
	logic [TIMER_W-1:0] wd_lim, safe_lim, top_lim;

	function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] r3,
		input logic [7:0] r4, input logic [7:0] r5);
		case (a)
			PRECHG_TERM_ADDR: reg_read = r3;
			CHARGE_VOLTAGE_CODE_TOPOFF_ADDR: reg_read = r4;
			TERM_WD_TIMER_ADDR: reg_read = r5;
			default: reg_read = 8'h00;
		endcase
	endfunction

	cttc_sync #(.W(2), .INIT(2'h3)) u_sync (
		.clk(MCLK),
		.rst_n(RESET_N),
		.din({SCL_I, SDA_I}),
		.dout({scl, sda})
	);

	// timer controls
	always_comb begin
		wd_code = q.r05[WD_LSB +: 2];
		top_code = q.r04[TOPOFF_LSB +: 2];
		term_cond = q.cfg.term_en && TERM_DETECT;
		por_load = REG_RESET || wd_exp;
		wd_run = wd_code != 2'h0;
		wd_clear = !wd_run || WATCHDOG_RESTART || wd_exp || REG_RESET;
		wd_lim = TIMER_W'(q.cfg.watchdog_s);
		safe_run = q.cfg.timer_en && (PRECHARGE_ACTIVE || FASTCHARGE_ACTIVE);
		safe_clear = !(PRECHARGE_ACTIVE || FASTCHARGE_ACTIVE) || por_load;
		safe_lim = TIMER_W'(int'(q.cfg.safety_hrs) * SEC_PER_HR);
		top_run = term_cond && !q.done && top_code != 2'h0;
		top_clear = !term_cond || q.done || por_load;
		top_lim = TIMER_W'(int'(q.cfg.topoff_min) * SEC_PER_MIN);
	end

	cttc_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_wd (
		.clk(MCLK),
		.rst_n(RESET_N),
		.run(wd_run),
		.clear(wd_clear),
		.limit_s(wd_lim),
		.expired(wd_exp)
	);

	cttc_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_safe (
		.clk(MCLK),
		.rst_n(RESET_N),
		.run(safe_run),
		.clear(safe_clear),
		.limit_s(safe_lim),
		.expired(safe_exp)
	);

	cttc_sec_timer #(.SEC_CYCLES(SEC_CYCLES)) u_top (
		.clk(MCLK),
		.rst_n(RESET_N),
		.run(top_run),
		.clear(top_clear),
		.limit_s(top_lim),
		.expired(top_exp)
	);

	always_comb begin
		logic [3:0] pc;
		logic [4:0] vc;
		logic wr_en;
		pc = '0;
		vc = '0;
		wr_en = 1'b0;
		d = q;
		d.scl_p = scl;
		d.sda_p = sda;
		d.rchg = 1'b0;
		d.wd_clr = WATCHDOG_RESTART || wd_exp;

		// serial port
		if (scl && q.scl_p && q.sda_p && !sda) begin
			d.st = ST_ADDR;
			d.bitcnt = '0;
			d.sda_oe = 1'b0;
		end else if (scl && q.scl_p && !q.sda_p && sda) begin
			d.st = ST_IDLE;
			d.sda_oe = 1'b0;
		end else if (scl && !q.scl_p) begin
			case (q.st)
				ST_ADDR, ST_PTR, ST_WR: begin
					d.sr = {q.sr[6:0], sda};
					d.bitcnt = q.bitcnt + 4'h1;
				end
				ST_RACK: d.ack_ok = !sda;
				default: d.ack_ok = q.ack_ok;
			endcase
		end else if (!scl && q.scl_p) begin
			case (q.st)
				ST_ADDR: begin
					if (q.bitcnt == 4'h8) begin
						if (q.sr[7:1] == DEV_ADDR) begin
							d.st = ST_AACK;
							d.rw = q.sr[0];
							d.sda_oe = 1'b1;
						end else begin
							d.st = ST_IDLE;
						end
					end
				end
				ST_AACK: begin
					d.bitcnt = '0;
					if (q.rw) begin
						d.tx = reg_read(q.ptr, q.r03, q.r04, q.r05);
						d.sda_oe = !d.tx[7];
						d.st = ST_RD;
					end else begin
						d.sda_oe = 1'b0;
						d.st = ST_PTR;
					end
				end
				ST_PTR: begin
					if (q.bitcnt == 4'h8) begin
						d.ptr = q.sr;
						d.sda_oe = 1'b1;
						d.st = ST_PACK;
					end
				end
				ST_PACK, ST_WACK: begin
					if (q.st == ST_WACK) begin
						d.ptr = q.ptr + 8'h01;
					end
					d.sda_oe = 1'b0;
					d.bitcnt = '0;
					d.st = ST_WR;
				end
				ST_WR: begin
					if (q.bitcnt == 4'h8) begin
						wr_en = 1'b1;
						d.sda_oe = 1'b1;
						d.st = ST_WACK;
					end
				end
				ST_RD: begin
					if (q.bitcnt == 4'h7) begin
						d.sda_oe = 1'b0;
						d.st = ST_RACK;
					end else begin
						d.tx = {q.tx[6:0], 1'b0};
						d.sda_oe = !d.tx[7];
						d.bitcnt = q.bitcnt + 4'h1;
					end
				end
				ST_RACK: begin
					if (q.ack_ok) begin
						d.ptr = q.ptr + 8'h01;
						d.tx = reg_read(d.ptr, q.r03, q.r04, q.r05);
						d.sda_oe = !d.tx[7];
						d.bitcnt = '0;
						d.st = ST_RD;
					end else begin
						d.st = ST_IDLE;
					end
				end
				default: d.st = ST_IDLE;
			endcase
		end

		// register bank; reset requests beat a same-cycle write
		if (por_load) begin
			d.r03 = PRECHG_TERM_POR;
			d.r04 = CHARGE_VOLTAGE_CODE_TOPOFF_POR;
			d.r05 = TERM_WD_TIMER_POR;
		end else if (wr_en) begin
			case (q.ptr)
				PRECHG_TERM_ADDR: d.r03 = q.sr;
				CHARGE_VOLTAGE_CODE_TOPOFF_ADDR: d.r04 = q.sr;
				TERM_WD_TIMER_ADDR: d.r05 = q.sr;
				default: d.r03 = q.r03;
			endcase
		end

		// decode; one cycle behind the bank
		pc = q.r03[PRECHG_LSB +: 4];
		if (pc > 4'(PRECHG_MAX_CODE)) begin
			pc = 4'(PRECHG_MAX_CODE);
		end
		d.cfg.precharge_ma = 10'(CUR_OFS_MA + CUR_STEP_MA * int'(pc));
		d.cfg.term_ma = 10'(CUR_OFS_MA + CUR_STEP_MA * int'(q.r03[TERM_LSB +: 4]));
		vc = q.r04[CHARGE_VOLTAGE_CODE_LSB +: 5];
		if (vc > 5'(CHARGE_VOLTAGE_CODE_MAX_CODE)) begin
			vc = 5'(CHARGE_VOLTAGE_CODE_MAX_CODE);
		end
		if (vc == 5'(CHARGE_VOLTAGE_CODE_SPECIAL_CODE)) begin
			d.cfg.charge_voltage_code_mv = 13'(CHARGE_VOLTAGE_CODE_SPECIAL_MV);
		end else begin
			d.cfg.charge_voltage_code_mv = 13'(CHARGE_VOLTAGE_CODE_OFS_MV + CHARGE_VOLTAGE_CODE_STEP_MV * int'(vc));
		end
		d.cfg.topoff_min = 6'(TOPOFF_STEP_MIN * int'(top_code));
		d.cfg.recharge_ofs_mv = q.r04[RECHG_BIT] ? 8'(RECHG_HIGH_MV) : 8'(RECHG_LOW_MV);
		d.cfg.term_en = q.r05[TERM_EN_BIT];
		d.cfg.watchdog_s = (wd_code == 2'h0) ? 8'h00 :
			8'(WD_BASE_S << (int'(wd_code) - 1));
		d.cfg.timer_en = q.r05[TIMER_EN_BIT];
		d.cfg.safety_hrs = q.r05[SAFETY_LEN_BIT] ? 3'(SAFETY_LONG_HR) : 3'(SAFETY_SHORT_HR);
		d.cfg.thermal_c = q.r05[TLIM_BIT] ? 7'(TLIM_HIGH_C) : 7'(TLIM_LOW_C);
		d.cfg.cold_pct = q.r05[COLD_BIT] ? 7'(COLD_FIFTH_PCT) : 7'(COLD_HALF_PCT);

		// termination, top-off and recharge
		if (q.done) begin
			if (VBAT_MV < q.cfg.charge_voltage_code_mv - 13'(q.cfg.recharge_ofs_mv)) begin
				d.rchg = 1'b1;
				d.done = 1'b0;
			end
		end else if (term_cond && (top_code == 2'h0 || top_exp)) begin
			d.done = 1'b1;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RESET_N) begin
			q <= '0;
			q.r03 <= PRECHG_TERM_POR;
			q.r04 <= CHARGE_VOLTAGE_CODE_TOPOFF_POR;
			q.r05 <= TERM_WD_TIMER_POR;
			q.st <= ST_IDLE;
			q.scl_p <= 1'b1;
			q.sda_p <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign SDA_O = 1'b0;
	assign SDA_OE = q.sda_oe;
	assign WATCHDOG_RESTART_CLEAR = q.wd_clr;
	assign WATCHDOG_EXPIRED = wd_exp;
	assign CHARGE_DONE = q.done;
	assign RECHARGE_START = q.rchg;
	assign SAFETY_EXPIRED = safe_exp;
	assign CFG = q.cfg;

	a_pre_decode: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(q.r03[7:4] <= 4'hc) |=> (q.cfg.precharge_ma == 10'(60 + 60 * int'($past(q.r03[7:4])))))
		else $error("pre-charge current decode wrong");
	a_pre_clamp: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(q.r03[7:4] > 4'hc) |=> (q.cfg.precharge_ma == 10'd780))
		else $error("pre-charge current not clamped");
	a_term_decode: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(q.r03[3:0] == 4'hf) |=> (q.cfg.term_ma == 10'd960))
		else $error("termination current decode wrong");
	a_charge_voltage_code_linear: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(q.r04[7:3] <= 5'h18 && q.r04[7:3] != 5'h0f)
		|=> (q.cfg.charge_voltage_code_mv == 13'(3856 + 32 * int'($past(q.r04[7:3])))))
		else $error("charge voltage decode wrong");
	a_charge_voltage_code_special: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(q.r04[7:3] == 5'h0f) |=> (q.cfg.charge_voltage_code_mv == 13'd4352))
		else $error("charge voltage special code wrong");
	a_charge_voltage_code_clamp: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(q.r04[7:3] > 5'h18) |=> (q.cfg.charge_voltage_code_mv == 13'd4624))
		else $error("charge voltage not clamped");
	a_topoff_off_done: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(!q.done && q.cfg.term_en && TERM_DETECT && q.r04[2:1] == 2'h0) |=> q.done)
		else $error("charge did not end at termination");
	a_topoff_wait: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(!q.done && !top_exp && q.r04[2:1] != 2'h0) |=> !q.done)
		else $error("charge ended before top-off expiry");
	a_recharge_ofs: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		RECHARGE_START |-> $past(q.done)
		&& ($past(VBAT_MV) < $past(q.cfg.charge_voltage_code_mv) - 13'($past(q.cfg.recharge_ofs_mv))))
		else $error("recharge started without cause");
	a_wd_disable: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(q.r05[5:4] == 2'h0)[*2] |=> !wd_exp)
		else $error("disabled watchdog expired");
	a_safety_len: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		q.r05[2] |=> (q.cfg.safety_hrs == 3'd6))
		else $error("safety timer length wrong");
	a_cold_thermal: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(!q.r05[1] && q.r05[0]) |=> (q.cfg.thermal_c == 7'd80 && q.cfg.cold_pct == 7'd20))
		else $error("thermal or cold decode wrong");
	a_por_load: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		(REG_RESET || wd_exp) |=> (q.r03 == 8'h22 && q.r04 == 8'h58 && q.r05 == 8'h9f))
		else $error("power-on values not restored");
	a_wd_clear: assert property (
		@(posedge MCLK) disable iff (!RESET_N)
		WATCHDOG_RESTART |=> WATCHDOG_RESTART_CLEAR ##1 !wd_exp)
		else $error("watchdog restart not acknowledged");
endmodule
`default_nettype wire

// File: rtl/cttc_sec_timer.sv
// Purpose: seconds timer with prescaler and sticky expiry
// Assumes: limit_s steady while running; zero limit never expires
// Notes: clear beats counting, but an expiry in the clearing cycle still shows
`timescale 1ns/1ps
`default_nettype none
module cttc_sec_timer
	import cttc_pkg::*;
#(
	parameter int SEC_CYCLES = SEC_CYCLES_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic run,
	input wire logic clear,
	input wire logic [TIMER_W-1:0] limit_s,
	// status
	output logic expired
);
	typedef struct packed {
		logic [31:0] pre;
		logic [TIMER_W-1:0] sec;
		logic exp;
	} cttc_tmr_s;
	cttc_tmr_s q, d;

	if (SEC_CYCLES < 2) begin : g_chk
		$error("SEC_CYCLES must be at least 2");
	end

	always_comb begin
		logic hit;
		hit = run && !q.exp && q.pre == 32'(SEC_CYCLES - 1) && limit_s != '0;
		hit = hit && (q.sec + 1'b1) >= limit_s;
		d = q;
		if (clear) begin
			d = '0;
			// set beats clear, so a same-cycle clear cannot swallow the expiry
			d.exp = hit;
		end else if (run && !q.exp) begin
			if (q.pre == 32'(SEC_CYCLES - 1)) begin
				d.pre = '0;
				d.sec = q.sec + 1'b1;
				if (limit_s != '0 && d.sec >= limit_s) begin
					d.exp = 1'b1;
				end
			end else begin
				d.pre = q.pre + 32'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign expired = q.exp;
endmodule
`default_nettype wire

// File: rtl/cttc_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module cttc_sync #(
	parameter int W = 2,
	parameter logic [W-1:0] INIT = '1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins in, filtered out
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] filt;
	} cttc_sync_s;
	cttc_sync_s q, d;

	always_comb begin
		d = q;
		d.s1 = din;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.filt[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= {INIT, INIT, INIT, INIT};
		end else begin
			q <= d;
		end
	end

	assign dout = q.filt;
endmodule
`default_nettype wire

// File: rtl/dummy_end_marker_not_used.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: sim/cttc_host.sv
// Purpose: two-wire bus master standing in for the host processor
// Assumes: pull-up on the data line; lines change on the falling MCLK edge
// Notes: scl high phases of HALF cycles and low phases of HALF plus 2, above the eight-cycle minimum
`timescale 1ns/1ps
`default_nettype none
module cttc_host (
	// clock
	input wire logic clk,
	// bus lines
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	localparam int HALF = 9;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hw(input int n);
		repeat (n) @(negedge clk);
	endtask
	// also a repeated start, so scl may be low on entry
	task automatic start();
		sda_low = 1'b0;
		hw(HALF);
		scl = 1'b1;
		hw(HALF);
		sda_low = 1'b1;
		hw(HALF);
		scl = 1'b0;
		hw(2);
	endtask
	task automatic stop();
		sda_low = 1'b1;
		hw(HALF);
		scl = 1'b1;
		hw(HALF);
		sda_low = 1'b0;
		hw(HALF);
	endtask
	// data moves two cycles after scl falls, so it never looks like a start
	task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
		output logic nine);
		logic [8:0] o;
		o = {tx, last};
		for (int k = 8; k >= 0; k--) begin
			sda_low = ~o[k];
			hw(HALF);
			scl = 1'b1;
			hw(HALF);
			o[k] = sda;
			scl = 1'b0;
			hw(2);
		end
		rx = o[8:1];
		nine = o[0];
	endtask
	// acks: one bit per byte, 0 when the device pulled low
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] val,
		output logic [2:0] acks);
		logic [7:0] rx;
		start();
		xfer({dev, 1'b0}, 1'b1, rx, acks[2]);
		xfer(ptr, 1'b1, rx, acks[1]);
		xfer(val, 1'b1, rx, acks[0]);
		stop();
	endtask
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] val,
		output logic [2:0] acks);
		logic [7:0] rx;
		logic nack;
		start();
		xfer({dev, 1'b0}, 1'b1, rx, acks[2]);
		xfer(ptr, 1'b1, rx, acks[1]);
		start();
		xfer({dev, 1'b1}, 1'b1, rx, acks[0]);
		xfer(8'hff, 1'b1, val, nack);
		stop();
	endtask
endmodule
`default_nettype wire

// File: sim/tb_cttc_regs.sv
// Purpose: self-checking bench for the charge configuration bank
// Assumes: SEC_CYCLES shrunk so every duration is a short cycle count
// Notes: expected decode is worked out here from the field tables
`timescale 1ns/1ps
`default_nettype none
module tb_cttc_regs
	import cttc_pkg::*;
;
	localparam int SECC = 2;
	localparam logic [6:0] DEV = 7'h55;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic reg_reset = 1'b0;
	logic wd_restart = 1'b1;
	logic pre_act = 1'b0;
	logic fast_act = 1'b0;
	logic term_det = 1'b0;
	logic [12:0] vbat = 13'd4200;
	logic scl, sda_low, sda_o, sda_oe, wd_clr, wd_exp, done, rechg, safe_exp;
	cttc_cfg_s cfg;
	wire logic sda = ~((sda_oe & ~sda_o) | sda_low);
	int miscompares = 0;
	int n_checks = 0;
	int n;
	int t;
	logic [7:0] shadow [3:5];
	always #2.5 clk = ~clk;
	cttc_regs #(.DEV_ADDR(DEV), .SEC_CYCLES(SECC)) dut (.MCLK(clk), .RESET_N(rst_n),
		.SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .REG_RESET(reg_reset),
		.WATCHDOG_RESTART(wd_restart), .WATCHDOG_RESTART_CLEAR(wd_clr),
		.WATCHDOG_EXPIRED(wd_exp), .PRECHARGE_ACTIVE(pre_act), .FASTCHARGE_ACTIVE(fast_act),
		.TERM_DETECT(term_det), .VBAT_MV(vbat), .CHARGE_DONE(done), .RECHARGE_START(rechg),
		.SAFETY_EXPIRED(safe_exp), .CFG(cfg));
	cttc_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));

	function automatic cttc_cfg_s exp_cfg(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c);
		cttc_cfg_s e;
		int p;
		int v;
		p = (a[7:4] > 4'd12) ? 12 : int'(a[7:4]);
		v = (b[7:3] > 5'd24) ? 24 : int'(b[7:3]);
		e.precharge_ma = 10'(60 + 60 * p);
		e.term_ma = 10'(60 + 60 * int'(a[3:0]));
		e.charge_voltage_code_mv = 13'((v == 15) ? 4352 : 3856 + 32 * v);
		e.topoff_min = 6'(15 * int'(b[2:1]));
		e.recharge_ofs_mv = b[0] ? 8'd200 : 8'd100;
		e.term_en = c[7];
		e.watchdog_s = (c[5:4] == 2'd0) ? 8'd0 : 8'(20 << c[5:4]);
		e.timer_en = c[3];
		e.safety_hrs = c[2] ? 3'd6 : 3'd4;
		e.thermal_c = c[1] ? 7'd120 : 7'd80;
		e.cold_pct = c[0] ? 7'd20 : 7'd50;
		return e;
	endfunction
	task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic set_por();
		shadow[3] = 8'h22;
		shadow[4] = 8'h58;
		shadow[5] = 8'h9f;
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] v);
		logic [2:0] a;
		host.write_reg(DEV, p, v, a);
		chk("write acks", 3'b000, a);
		if (p inside {[3:5]})
			shadow[p] = v;
		cyc(3);
		chk("decoded config", exp_cfg(shadow[3], shadow[4], shadow[5]), cfg);
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		logic [2:0] a;
		logic [7:0] v;
		host.read_reg(DEV, p, v, a);
		chk("read acks", 3'b000, a);
		chk("read data", e, v);
	endtask
	task automatic rd_all();
		for (int k = 3; k <= 5; k++)
			rd(8'(k), shadow[k]);
	endtask

	initial begin
		repeat (99000) @(posedge clk);
		miscompares++;
		close_out();
	end

	initial begin
		logic [2:0] a;
		set_por();
		cyc(8);
		rst_n = 1'b1;
		cyc(6);
		chk("power-on config", exp_cfg(8'h22, 8'h58, 8'h9f), cfg);
		rd_all();
		for (int i = 0; i < 16; i++)
			wr(8'h03, {i[3:0], 4'(15 - i)});
		for (int i = 0; i < 32; i++)
			wr(8'h04, {i[4:0], i[1:0], i[2]});
		for (int i = 0; i < 16; i++)
			wr(8'h05, {i[3], 1'b0, i[1:0], i[2], i[0], i[1], i[3]});
		wr(8'h07, 8'h5a);
		rd(8'h07, 8'h00);
		rd_all();
		host.write_reg(7'h2a, 8'h03, 8'h00, a);
		chk("foreign address", 3'b111, a);
		rd_all();
		reg_reset = 1'b1;
		cyc(1);
		reg_reset = 1'b0;
		cyc(3);
		set_por();
		chk("config after reload", exp_cfg(8'h22, 8'h58, 8'h9f), cfg);
		rd_all();
		// 15 minute top-off with the 200 mV recharge offset
		wr(8'h04, 8'h5b);
		term_det = 1'b1;
		t = 15 * 60 * SECC;
		n = 0;
		while (done !== 1'b1 && n < 2 * t) begin
			cyc(1);
			n++;
		end
		chk("top-off span", 1'b1, 1'(n >= t - 3 && n <= t + 3));
		term_det = 1'b0;
		vbat = 13'd4008;
		cyc(5);
		chk("done above threshold", 1'b1, done);
		vbat = 13'd4007;
		cyc(3);
		chk("done after recharge", 1'b0, done);
		vbat = 13'd4200;
		wr(8'h04, 8'h58);
		term_det = 1'b1;
		cyc(3);
		chk("immediate done", 1'b1, done);
		term_det = 1'b0;
		vbat = 13'd4108;
		cyc(5);
		chk("done above threshold", 1'b1, done);
		vbat = 13'd4107;
		n = 0;
		while (rechg !== 1'b1 && n < 5) begin
			cyc(1);
			n++;
		end
		chk("recharge pulse", 1'b1, rechg);
		vbat = 13'd4200;
		// 4 hour safety timer, half pre-charge and half fast charge
		wr(8'h05, 8'h9b);
		t = 4 * 3600 * SECC;
		pre_act = 1'b1;
		cyc(t / 2);
		pre_act = 1'b0;
		fast_act = 1'b1;
		cyc(t / 2 - 10);
		chk("safety early", 1'b0, safe_exp);
		cyc(20);
		chk("safety expiry", 1'b1, safe_exp);
		fast_act = 1'b0;
		wr(8'h04, 8'h5a);
		wr(8'h05, 8'h9f);
		wd_restart = 1'b0;
		t = 40 * SECC;
		n = 0;
		while (wd_exp !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		chk("watchdog span", 1'b1, 1'(n >= t - 3 && n <= t + 3));
		cyc(3);
		set_por();
		chk("config after expiry", exp_cfg(8'h22, 8'h58, 8'h9f), cfg);
		wd_restart = 1'b1;
		n = 0;
		while (wd_clr !== 1'b1 && n < 3) begin
			cyc(1);
			n++;
		end
		chk("restart clear", 1'b1, wd_clr);
		rd_all();
		close_out();
	end
endmodule
`default_nettype wire
